// [rtl/uart_regs_pkg.sv]
package uart_regs_pkg;
    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [2:0] OFS_BAUD_DIVISOR_LOW   = 3'h0;
    localparam logic [2:0] OFS_BAUD_DIVISOR_HIGH  = 3'h1;
    localparam logic [2:0] OFS_INTERRUPT_IDENT    = 3'h2;

    // ------------------------------------------------------------------
    // Bank select and fields
    // ------------------------------------------------------------------
    localparam int         LFC_BANK_BIT           = 7;
    localparam logic [7:0] LFC_ENHANCED_KEY       = 8'hBF;
    localparam int         QC_QUEUE_EN_BIT        = 0;
    localparam int         IE_LINE_STATUS_BIT     = 2;

    // ------------------------------------------------------------------
    // Reset values and identification codes
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_BAUD_DIVISOR_LOW   = 8'h01;
    localparam logic [7:0] RST_BAUD_DIVISOR_HIGH  = 8'h00;
    localparam logic [7:0] RST_INTERRUPT_IDENT    = 8'h01;
    localparam logic [4:0] SRC_NONE               = 5'h00;
    localparam logic [4:0] SRC_LINE_STATUS        = 5'h03;
endpackage : uart_regs_pkg

// [rtl/irq_prioritizer.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Picks the highest ranked enabled source
// ----------------------------------------------------------------------
module irq_prioritizer #(
    parameter int N = 1
) (
    input  wire logic [N-1:0]   pending,
    input  wire logic [N*5-1:0] codes,
    output logic                any,
    output logic [4:0]          code
);
    logic [N:0]     hit;
    logic [N*5+4:0] sel;

    assign hit[0]     = 1'b0;
    assign sel[4:0]   = uart_regs_pkg::SRC_NONE;

    // Index 0 ranks highest; later entries only win when all above are idle
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_rank
            assign hit[i+1]         = hit[i] | pending[i];
            assign sel[i*5+9:i*5+5] = (!hit[i] && pending[i]) ? codes[i*5+4:i*5]
                                                              : sel[i*5+4:i*5];
        end
    endgenerate

    assign any  = hit[N];
    assign code = sel[N*5+4:N*5];
endmodule : irq_prioritizer

// [rtl/uart_divisor_irq_regs.sv]
`timescale 1ns/1ps
// Overview of operation
// - Divisor high at 0x01 when bank bit set, not BF
// - Divisor high gives upper eight divisor bits
// - Divisor high clears only on power-on reset
// - Read-only ident at 0x02, bank bit clear, reset 01
// - Ident bits 7:6 mirror queue enable bit
// - Ident bit 0 low while interrupt pending
// - Line status error reads 000110, top priority
// - Divisor low at 0x00, same bank, resets 01
// - Line status reported only when enabled
module uart_divisor_irq_regs (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        soft_rst,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [2:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic [7:0]       reg_rdata,
    output logic             reg_hit,
    input  wire logic [7:0]  line_format_control,
    input  wire logic [7:0]  queue_control,
    input  wire logic [7:0]  interrupt_enables,
    input  wire logic        line_status_err,
    output logic [15:0]      baud_divisor,
    output logic             irq_pending
);
    // ------------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------------
    logic [1:0] rst_sync;
    logic       rst_n_int;

    // Async assert, synchronous release to avoid recovery hazards
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n_int = rst_sync[1];

    // ------------------------------------------------------------------
    // Bank decode
    // ------------------------------------------------------------------
    logic div_bank;
    logic norm_bank;
    logic wr_div_low;
    logic wr_div_high;
    logic rd_ident;

    assign div_bank    = line_format_control[uart_regs_pkg::LFC_BANK_BIT]
                         && (line_format_control != uart_regs_pkg::LFC_ENHANCED_KEY);
    assign norm_bank   = !line_format_control[uart_regs_pkg::LFC_BANK_BIT];
    assign wr_div_low  = reg_wr && div_bank
                         && (reg_addr == uart_regs_pkg::OFS_BAUD_DIVISOR_LOW);
    assign wr_div_high = reg_wr && div_bank
                         && (reg_addr == uart_regs_pkg::OFS_BAUD_DIVISOR_HIGH);
    assign rd_ident    = norm_bank && (reg_addr == uart_regs_pkg::OFS_INTERRUPT_IDENT);

    // ------------------------------------------------------------------
    // Divisor latches
    // ------------------------------------------------------------------
    logic [7:0] baud_divisor_low;
    logic [7:0] baud_divisor_high;

    // Only power-on reset clears them; soft reset must keep the baud rate
    always_ff @(posedge core_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            baud_divisor_low <= uart_regs_pkg::RST_BAUD_DIVISOR_LOW;
        end else if (wr_div_low) begin
            baud_divisor_low <= reg_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            baud_divisor_high <= uart_regs_pkg::RST_BAUD_DIVISOR_HIGH;
        end else if (wr_div_high) begin
            baud_divisor_high <= reg_wdata;
        end
    end

    // Upper byte forms the top of the generator divisor
    assign baud_divisor = {baud_divisor_high, baud_divisor_low};

    // ------------------------------------------------------------------
    // Interrupt identification
    // ------------------------------------------------------------------
    logic       src_any;
    logic [4:0] src_code;
    logic       ls_active;

    assign ls_active = line_status_err
                       && interrupt_enables[uart_regs_pkg::IE_LINE_STATUS_BIT];

    // Further sources append below; entry 0 ranks first
    irq_prioritizer #(
        .N       (1)
    ) u_prio (
        .pending (ls_active),
        .codes   (uart_regs_pkg::SRC_LINE_STATUS),
        .any     (src_any),
        .code    (src_code)
    );

    logic [7:0] ident;
    logic [7:0] next_ident;
    logic       qen;

    assign qen = queue_control[uart_regs_pkg::QC_QUEUE_EN_BIT];

    // Assembled live; registered so the host sees a stable byte
    always_comb begin
        next_ident      = 8'h00;
        next_ident[7:6] = {qen, qen};
        next_ident[5:1] = src_code;
        next_ident[0]   = !src_any;
    end

    // Soft reset also returns ident to its default
    always_ff @(posedge core_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            ident <= uart_regs_pkg::RST_INTERRUPT_IDENT;
        end else if (soft_rst) begin
            ident <= uart_regs_pkg::RST_INTERRUPT_IDENT;
        end else begin
            ident <= next_ident;
        end
    end

    assign irq_pending = !ident[0];

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            reg_rdata <= 8'h00;
            reg_hit   <= 1'b0;
        end else begin
            reg_hit   <= 1'b0;
            reg_rdata <= 8'h00;
            if (reg_rd) begin
                if (div_bank && reg_addr == uart_regs_pkg::OFS_BAUD_DIVISOR_LOW) begin
                    reg_rdata <= baud_divisor_low;
                    reg_hit   <= 1'b1;
                end else if (div_bank
                             && reg_addr == uart_regs_pkg::OFS_BAUD_DIVISOR_HIGH) begin
                    reg_rdata <= baud_divisor_high;
                    reg_hit   <= 1'b1;
                end else if (rd_ident) begin
                    reg_rdata <= ident;
                    reg_hit   <= 1'b1;
                end
            end
        end
    end
endmodule : uart_divisor_irq_regs

// [bench/uart_divisor_irq_regs_chk.sv]
`timescale 1ns/1ps
module uart_divisor_irq_regs_chk (
    input wire logic        core_clk,
    input wire logic        rstn,
    input wire logic        soft_rst,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [2:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    input wire logic        reg_hit,
    input wire logic [7:0]  line_format_control,
    input wire logic [7:0]  queue_control,
    input wire logic [7:0]  interrupt_enables,
    input wire logic        line_status_err,
    input wire logic [15:0] baud_divisor,
    input wire logic        irq_pending
);
    // Bank decode and the one modelled source
    logic ok;
    logic src;
    assign ok  = line_format_control[7] && line_format_control != 8'hBF;
    assign src = line_status_err && interrupt_enables[2];
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // Ident read with inputs settled and no soft reset nearby
    sequence ident_rd_s;
        reg_rd && reg_addr == 3'h2 && !line_format_control[7] && !soft_rst && !$past(soft_rst)
            && $stable(src) && $stable(queue_control[0]);
    endsequence
    rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00 && !reg_hit)
        else $error("read data not idle");
    bank_hit_a: assert property (reg_rd && reg_addr <= 3'h1 && ok |=> reg_hit)
        else $error("divisor read missed");
    key_miss_a: assert property (reg_rd && !ok && line_format_control[7] |=> !reg_hit)
        else $error("read hit under key value");
    ident_hit_a: assert property (reg_rd && reg_addr == 3'h2 |=> reg_hit == !$past(line_format_control[7]))
        else $error("ident bank wrong");
    ident_val_a: assert property (ident_rd_s |=> reg_rdata == {{2{$past(queue_control[0])}},
        $past(src) ? 5'h03 : 5'h00, !$past(src)}) else $error("ident value wrong");
    high_wr_a: assert property (reg_wr && reg_addr == 3'h1 && ok |=> baud_divisor[15:8] == $past(reg_wdata))
        else $error("high byte not written");
    low_wr_a: assert property (reg_wr && reg_addr == 3'h0 && ok |=> baud_divisor[7:0] == $past(reg_wdata))
        else $error("low byte not written");
    soft_keep_a: assert property ((soft_rst || !ok) && !reg_wr |=> $stable(baud_divisor))
        else $error("divisor changed");
    irq_lag_a: assert property (!$past(soft_rst) |-> irq_pending == $past(src))
        else $error("pending flag wrong");
endmodule : uart_divisor_irq_regs_chk

// [bench/host_master_model.sv]
`timescale 1ns/1ps
module host_master_model (
    input  wire logic       core_clk,
    output logic            reg_wr = 1'b0,
    output logic            reg_rd = 1'b0,
    output logic [2:0]      reg_addr = 3'h0,
    output logic [7:0]      reg_wdata = 8'h00,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_hit
);
    // A free edge before each strobe keeps transfers apart
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk) #1;
        {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        @(posedge core_clk) #1;
        {reg_wr, reg_wdata} = {1'b0, ~d}; // Stale data never lingers
    endtask : wr_reg
    // Answer is registered, so it is taken one edge after the request
    task automatic rd_reg(input logic [2:0] a, output logic [7:0] d, output logic h);
        @(posedge core_clk) #1;
        {reg_addr, reg_rd} = {a, 1'b1};
        @(posedge core_clk) #1;
        {reg_rd, d, h} = {1'b0, reg_rdata, reg_hit};
    endtask : rd_reg
endmodule : host_master_model

// [bench/uart_divisor_irq_regs_tb.sv]
`timescale 1ns/1ps
module uart_divisor_irq_regs_tb;
    logic        core_clk = 1'b0, rstn = 1'b0, soft_rst = 1'b0, line_status_err = 1'b0;
    logic        reg_wr, reg_rd, reg_hit, irq_pending, hit;
    logic [2:0]  reg_addr, a;
    logic [7:0]  reg_wdata, reg_rdata, got, d, lo = 8'h01, hi = 8'h00;
    logic [7:0]  line_format_control = 8'h00, queue_control = 8'h00, interrupt_enables = 8'h00;
    logic [15:0] baud_divisor;
    logic [7:0]  lfc_tab [4] = '{8'h80, 8'hBF, 8'h03, 8'hC3};
    int          num_errors = 0, n_compared = 0;
    always #20 core_clk = ~core_clk;
    host_master_model i_host_master_model (.*);
    uart_divisor_irq_regs i_uart_divisor_irq_regs (.*);
    function automatic logic ok();
        return line_format_control[7] && line_format_control != 8'hBF;
    endfunction : ok
    // Expected {hit, data} of a read
    function automatic logic [15:0] exp_read(input logic [2:0] x);
        logic s;
        s = line_status_err && interrupt_enables[uart_regs_pkg::IE_LINE_STATUS_BIT];
        if (x == 3'h0 && ok()) return {8'h01, lo};
        if (x == 3'h1 && ok()) return {8'h01, hi};
        if (x == 3'h2 && !line_format_control[7]) return {8'h01, {2{queue_control[0]}},
            s ? uart_regs_pkg::SRC_LINE_STATUS : uart_regs_pkg::SRC_NONE, !s};
        return 16'h0000;
    endfunction : exp_read
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    // Watchdog sized well above the expected run
    initial begin
        #(1000 * 40);
        num_errors++;
        report_and_stop();
    end
    // Main sequence
    initial begin
        void'($urandom(32'h35b0cc71));
        repeat (8) @(posedge core_clk);
        #1 rstn = 1'b1;
        repeat (3) @(posedge core_clk);
        #1 line_format_control = 8'h80;
        i_host_master_model.rd_reg(3'h0, got, hit);
        chk({hit, got}, 16'h0101);
        i_host_master_model.rd_reg(3'h1, got, hit);
        chk({hit, got}, 16'h0100);
        $display("reset values done");
        for (int i = 0; i < 40; i++) begin
            line_format_control = lfc_tab[$urandom_range(3)];
            {queue_control, interrupt_enables, line_status_err} = 17'($urandom);
            {a, d} = {3'($urandom_range(3)), 8'($urandom)};
            i_host_master_model.wr_reg(a, d);
            if (a == 3'h0 && ok()) lo = d;
            if (a == 3'h1 && ok()) hi = d;
            chk(baud_divisor, {hi, lo});
            i_host_master_model.rd_reg(a, got, hit);
            chk({hit, got}, exp_read(a));
            chk(irq_pending, line_status_err && interrupt_enables[2]);
        end
        $display("random accesses done");
        {line_status_err, interrupt_enables} = {1'b1, 8'h04};
        @(posedge core_clk) #1 soft_rst = 1'b1;
        @(posedge core_clk) #1 soft_rst = 1'b0;
        chk(baud_divisor, {hi, lo});
        line_status_err = 1'b0;
        @(posedge core_clk) #1 rstn = 1'b0;
        @(posedge core_clk) #1 rstn = 1'b1;
        chk(baud_divisor, 16'h0001);
        $display("reset kinds done");
        report_and_stop();
    end
endmodule : uart_divisor_irq_regs_tb
bind uart_divisor_irq_regs uart_divisor_irq_regs_chk i_uart_divisor_irq_regs_chk (.*);
